/* rtl/quad_dac_control_register_bank.sv */
// Control register bank of a four-channel current-output DAC
// Behaviour
// - Writes are 24-bit frames with fixed fields
// - Selector all ones picks control registers
// - Global bit 11 enables status return on writes
// - Global bit 10 starts or stops the watchdog
// - Timeout select: 5, 10, 100, 200 ms
// - Global bit 5 enables all four outputs
// - Global bit 4 powers all four converters
// - Control selector 010 writes addressed channel register
// - Channel bit 8 powers internals, not output
// - Channel bit 7 lets clear pin reach channel
// - Channel bit 6 enables that channel's output
// - Channel bit 5: external or internal sense
// - Channel bit 4 powers that channel's converter
// - Range codes 100, 101, 110 decoded
// - Control selector 100 writes software register
// - Software user bit echoes into status bit 11
// - Missed keep-alive raises the alert output
// - Code 0x555 performs full software reset
module quad_dac_control_register_bank #(
  parameter int TICK_CYCLES = dac_ctrl_pkg::TICK_CYCLES  // Cycles per watchdog tick
) (
  input  wire logic        sys_clk_in,          // System clock, 125 MHz
  input  wire logic        resetn_in,           // Synchronous reset, active low
  input  wire logic        sclk_in,             // Serial clock pin
  input  wire logic        sync_n_in,           // Frame select pin, active low
  input  wire logic        sdi_in,              // Serial data in pin
  input  wire logic [1:0]  dev_addr_in,         // Device address straps
  input  wire logic        clear_in,            // Clear pin, active high
  output logic             sdo_out,             // Serial data out
  output logic             sdo_oe_out,          // Drive enable for serial data out
  output logic [3:0]       output_enable_out,   // Channel output enabled
  output logic [3:0]       converter_power_out, // Channel converter powered
  output logic [3:0]       internal_enable_out, // Channel DAC and amplifiers powered
  output logic [3:0]       sense_select_out,    // 1 internal, 0 external sense resistor
  output logic [11:0]      range_out,           // Range code, 3 bits per channel
  output logic [3:0]       channel_clear_out,   // Channel being cleared
  output logic             alert_out            // Watchdog fault, active high
);
  frame_if fr ();
  wd_if    wd ();

  typedef struct packed {
    logic [1:0]       dev_s1, dev_s2;    // Strap synchroniser
    logic             clr_s1, clr_s2;    // Clear pin synchroniser
    logic             status_on_write_enable; // Status return on writes
    logic             watchdog_enable;   // Watchdog running
    logic [1:0]       watchdog_timeout_select; // Timeout code
    logic             all_outputs_enable;   // Every output on
    logic             all_converters_power; // Every converter on
    logic [3:0]       int_enable;        // Per-channel internal enable
    logic [3:0]       channel_clear_enable; // Per-channel clear response
    logic [3:0]       channel_output_enable; // Per-channel output enable
    logic [3:0]       sense_resistor_select; // Per-channel sense choice
    logic [3:0]       channel_converter_power; // Per-channel converter
    logic [3:0][2:0]  output_range_code; // Per-channel range
    logic             user_bit;          // Echoed into status
    logic             kick;              // Keep-alive pulse
    logic [3:0]       oe_o, pwr_o, int_o, sense_o, clr_o; // Registered outputs
    logic [11:0]      range_o;
    logic             alert_o;
  } bank_st_t;

  // Reset image; range starts on a defined code rather than an unused one
  localparam bank_st_t BANK_RESET = '{
    output_range_code: {4{dac_ctrl_pkg::RANGE_RESET}},
    range_o:           {4{dac_ctrl_pkg::RANGE_RESET}},
    default:           '0
  };

  bank_st_t    q, n;
  logic        accept;
  logic [2:0]  ctl;
  logic [1:0]  chan;
  logic [15:0] data;
  logic [11:0] code;

  // Serial receiver, owns the serial pin synchronisers and readback shifter
  serial_frame_rx u_rx (
    .sys_clk_in (sys_clk_in),
    .resetn_in  (resetn_in),
    .sclk_in    (sclk_in),
    .sync_n_in  (sync_n_in),
    .sdi_in     (sdi_in),
    .sdo_out    (sdo_out),
    .sdo_oe_out (sdo_oe_out),
    .fr         (fr.rx)
  );

  // Interface watchdog
  watchdog_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_wd (
    .sys_clk_in (sys_clk_in),
    .resetn_in  (resetn_in),
    .wd         (wd.timer)
  );

  // Frame field split
  always_comb begin
    ctl    = fr.frame_data[dac_ctrl_pkg::F_CTL_HI:dac_ctrl_pkg::F_CTL_LO];
    chan   = fr.frame_data[dac_ctrl_pkg::F_CH_HI:dac_ctrl_pkg::F_CH_LO];
    data   = fr.frame_data[15:0];
    code   = data[dac_ctrl_pkg::S_CODE_HI:0];
    // Only writes to this device's address and the control selector are taken
    accept = fr.frame_valid
           & ~fr.frame_data[dac_ctrl_pkg::F_RW]
           & (fr.frame_data[dac_ctrl_pkg::F_DEV_HI:dac_ctrl_pkg::F_DEV_LO] == q.dev_s2)
           & (fr.frame_data[dac_ctrl_pkg::F_SEL_HI:dac_ctrl_pkg::F_SEL_LO]
              == dac_ctrl_pkg::SEL_CONTROL);
  end

  // Register writes and output composition
  always_comb begin
    n      = q;
    n.kick = 1'b0;
    if (accept) begin
      case (ctl)
        dac_ctrl_pkg::CTL_GLOBAL: begin
          n.status_on_write_enable  = data[dac_ctrl_pkg::G_STATUS_ON_WRITE];
          n.watchdog_enable         = data[dac_ctrl_pkg::G_WD_ENABLE];
          n.watchdog_timeout_select =
            data[dac_ctrl_pkg::G_WD_SEL_HI:dac_ctrl_pkg::G_WD_SEL_LO];
          n.all_outputs_enable      = data[dac_ctrl_pkg::G_ALL_OUTPUTS];
          n.all_converters_power    = data[dac_ctrl_pkg::G_ALL_CONVERTERS];
        end
        dac_ctrl_pkg::CTL_CHANNEL: begin
          // Only the addressed channel changes
          n.int_enable[chan]              = data[dac_ctrl_pkg::C_INT_ENABLE];
          n.channel_clear_enable[chan]    = data[dac_ctrl_pkg::C_CLEAR_EN];
          n.channel_output_enable[chan]   = data[dac_ctrl_pkg::C_OUTPUT_EN];
          n.sense_resistor_select[chan]   = data[dac_ctrl_pkg::C_SENSE_SEL];
          n.channel_converter_power[chan] = data[dac_ctrl_pkg::C_CONV_POWER];
          // An undefined range code keeps the old range
          if (dac_ctrl_pkg::range_valid(data[dac_ctrl_pkg::C_RANGE_HI:dac_ctrl_pkg::C_RANGE_LO]))
          begin
            n.output_range_code[chan] =
              data[dac_ctrl_pkg::C_RANGE_HI:dac_ctrl_pkg::C_RANGE_LO];
          end
        end
        dac_ctrl_pkg::CTL_SOFTWARE: begin
          n.user_bit = data[dac_ctrl_pkg::S_USER_BIT];
          if (code == dac_ctrl_pkg::CODE_RESET) begin
            // Everything but the pin synchronisers and alert_o, which follows wd.timeout, returns to reset
            n = BANK_RESET;
          end else if (code == dac_ctrl_pkg::CODE_KEEPALIVE) begin
            n.kick = 1'b1;
          end
        end
        default: begin
          // Other control registers are not held here
        end
      endcase
    end
    // Synchronisers: first stage feeds only the second
    n.dev_s1 = dev_addr_in;
    n.dev_s2 = q.dev_s1;
    n.clr_s1 = clear_in;
    n.clr_s2 = q.clr_s1;
    // Global bits OR onto the channel bits; mixing both is left to the host
    n.oe_o    = n.channel_output_enable | {4{n.all_outputs_enable}};
    n.pwr_o   = n.channel_converter_power | {4{n.all_converters_power}};
    n.int_o   = n.int_enable;
    n.sense_o = n.sense_resistor_select;
    n.range_o = n.output_range_code;
    n.clr_o   = n.channel_clear_enable & {4{q.clr_s2}};
    n.alert_o = wd.timeout;
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      q <= BANK_RESET;
    end else begin
      q <= n;
    end
  end

  // Status word returned during writes
  always_comb begin
    fr.status_word                        = 16'h0000;
    fr.status_word[dac_ctrl_pkg::ST_USER]  = q.user_bit;
    fr.status_word[dac_ctrl_pkg::ST_ALERT] = q.alert_o;
  end

  assign fr.readback_en = q.status_on_write_enable;
  assign wd.enable      = q.watchdog_enable;
  assign wd.sel         = q.watchdog_timeout_select;
  assign wd.kick        = q.kick;

  assign output_enable_out   = q.oe_o;
  assign converter_power_out = q.pwr_o;
  assign internal_enable_out = q.int_o;
  assign sense_select_out    = q.sense_o;
  assign range_out           = q.range_o;
  assign channel_clear_out   = q.clr_o;
  assign alert_out           = q.alert_o;
endmodule

/* rtl/dac_ctrl_pkg.sv */
// Shared constants, field positions and types for the DAC control register bank
package dac_ctrl_pkg;
  // Serial frame layout
  localparam int FRAME_BITS = 24;                  // Bits in one write frame
  localparam int F_RW       = 23;                  // Read/write flag
  localparam int F_DEV_HI   = 22;                  // Device address field
  localparam int F_DEV_LO   = 21;
  localparam int F_SEL_HI   = 20;                  // Register selector field
  localparam int F_SEL_LO   = 18;
  localparam int F_CH_HI    = 17;                  // Channel address field
  localparam int F_CH_LO    = 16;
  localparam int F_CTL_HI   = 15;                  // Control selector field
  localparam int F_CTL_LO   = 13;
  localparam logic [2:0] SEL_CONTROL  = 3'h7;      // Selector for control registers
  localparam logic [2:0] CTL_GLOBAL   = 3'h1;      // Global control register
  localparam logic [2:0] CTL_CHANNEL  = 3'h2;      // Per-channel control register
  localparam logic [2:0] CTL_SOFTWARE = 3'h4;      // Software command register
  // Global control fields
  localparam int G_STATUS_ON_WRITE = 11;
  localparam int G_WD_ENABLE       = 10;
  localparam int G_WD_SEL_HI       = 9;
  localparam int G_WD_SEL_LO       = 8;
  localparam int G_ALL_OUTPUTS     = 5;
  localparam int G_ALL_CONVERTERS  = 4;
  // Channel control fields
  localparam int C_INT_ENABLE  = 8;
  localparam int C_CLEAR_EN    = 7;
  localparam int C_OUTPUT_EN   = 6;
  localparam int C_SENSE_SEL   = 5;
  localparam int C_CONV_POWER  = 4;
  localparam int C_RANGE_HI    = 2;
  localparam int C_RANGE_LO    = 0;
  localparam logic [2:0] RANGE_4_20  = 3'h4;       // 4 to 20 mA
  localparam logic [2:0] RANGE_0_20  = 3'h5;       // 0 to 20 mA
  localparam logic [2:0] RANGE_0_24  = 3'h6;       // 0 to 24 mA
  localparam logic [2:0] RANGE_RESET = RANGE_4_20; // Range after reset
  // Software command fields
  localparam int S_USER_BIT = 12;
  localparam int S_CODE_HI  = 11;
  localparam logic [11:0] CODE_KEEPALIVE = 12'h195; // Watchdog keep-alive
  localparam logic [11:0] CODE_RESET     = 12'h555; // Full software reset
  // Status word readback positions
  localparam int ST_USER  = 11;
  localparam int ST_ALERT = 0;
  // Watchdog timing: a millisecond tick, then whole ticks per timeout
  localparam int CLK_HZ      = 125_000_000;
  localparam int TICK_MS     = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int WD_T0_MS    = 5;
  localparam int WD_T1_MS    = 10;
  localparam int WD_T2_MS    = 100;
  localparam int WD_T3_MS    = 200;
  localparam int TICK_W      = 17;                 // Holds TICK_CYCLES
  localparam int WD_CNT_W    = 8;                  // Holds the longest timeout in ticks

  // Receiver states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b01,
    RX_SHIFT = 2'b10
  } rx_state_t;

  // Timeout in ticks for a select code
  function automatic logic [WD_CNT_W-1:0] wd_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    wd_limit = WD_CNT_W'(WD_T0_MS / TICK_MS);
      2'h1:    wd_limit = WD_CNT_W'(WD_T1_MS / TICK_MS);
      2'h2:    wd_limit = WD_CNT_W'(WD_T2_MS / TICK_MS);
      default: wd_limit = WD_CNT_W'(WD_T3_MS / TICK_MS);
    endcase
  endfunction

  // True for the three defined range codes
  function automatic logic range_valid(input logic [2:0] code);
    range_valid = (code == RANGE_4_20) || (code == RANGE_0_20) || (code == RANGE_0_24);
  endfunction
endpackage

/* rtl/dac_ctrl_if.sv */
// Interfaces joining the register bank to its frame receiver and watchdog
interface frame_if;
  logic        frame_valid;  // One-cycle pulse, complete frame
  logic [23:0] frame_data;   // Received frame, stable with the pulse
  logic [15:0] status_word;  // Word returned during a write
  logic        readback_en;  // Return status during writes
  modport rx   (output frame_valid, frame_data, input status_word, readback_en);
  modport bank (input frame_valid, frame_data, output status_word, readback_en);
endinterface

interface wd_if;
  logic       enable;        // Watchdog running
  logic [1:0] sel;           // Timeout select
  logic       kick;          // One-cycle keep-alive pulse
  logic       timeout;       // Fault level
  modport timer (input enable, sel, kick, output timeout);
  modport bank  (output enable, sel, kick, input timeout);
endinterface

/* rtl/serial_frame_rx.sv */
// Serial frame receiver with status shift-out, sampled on the system clock
module serial_frame_rx (
  input  wire logic sys_clk_in,   // System clock
  input  wire logic resetn_in,    // Synchronous reset, active low
  input  wire logic sclk_in,      // Serial clock pin
  input  wire logic sync_n_in,    // Frame select pin, active low
  input  wire logic sdi_in,       // Serial data in
  output logic      sdo_out,      // Serial data out
  output logic      sdo_oe_out,   // Serial data out drive enable
  frame_if.rx       fr            // Frame towards the bank
);
  typedef struct packed {
    logic                    sclk_s1, sclk_s2, sclk_s3;  // Clock sync and history
    logic                    sync_s1, sync_s2, sync_s3;  // Select sync and history
    logic                    sdi_s1, sdi_s2;             // Data sync
    dac_ctrl_pkg::rx_state_t state;                      // Receiver state
    logic [23:0]             shift;                      // Incoming bits
    logic [4:0]              cnt;                        // Bits taken, saturates past 24
    logic                    valid;                      // Frame pulse
    logic [23:0]             out_shift;                  // Outgoing bits
    logic                    sdo, sdo_oe;                // Pin drive
  } rx_st_t;

  rx_st_t q, n;
  logic   sclk_fall, sclk_rise, sel_fall, sel_rise;

  // Edges are found on the second and third stages only
  always_comb begin
    n = q;
    n.valid   = 1'b0;
    n.sclk_s1 = sclk_in;
    n.sclk_s2 = q.sclk_s1;
    n.sclk_s3 = q.sclk_s2;
    n.sync_s1 = sync_n_in;
    n.sync_s2 = q.sync_s1;
    n.sync_s3 = q.sync_s2;
    n.sdi_s1  = sdi_in;
    n.sdi_s2  = q.sdi_s1;
    sclk_fall = q.sclk_s3 & ~q.sclk_s2;
    sclk_rise = ~q.sclk_s3 & q.sclk_s2;
    sel_fall  = q.sync_s3 & ~q.sync_s2;
    sel_rise  = ~q.sync_s3 & q.sync_s2;
    case (q.state)
      dac_ctrl_pkg::RX_IDLE: begin
        // Frame start: load the status word, first bit on the pin at once
        if (sel_fall) begin
          n.state     = dac_ctrl_pkg::RX_SHIFT;
          n.cnt       = 5'h00;
          n.out_shift = {8'h00, fr.status_word};
          n.sdo       = 1'b0;
          n.sdo_oe    = fr.readback_en;
        end
      end
      dac_ctrl_pkg::RX_SHIFT: begin
        if (sel_rise) begin
          // Only an exact 24-bit frame is passed on; others are dropped
          n.state  = dac_ctrl_pkg::RX_IDLE;
          n.sdo_oe = 1'b0;
          n.sdo    = 1'b0;
          n.valid  = (q.cnt == 5'(dac_ctrl_pkg::FRAME_BITS));
        end else begin
          // Data taken on falling edges, MSB first
          if (sclk_fall) begin
            n.shift = {q.shift[22:0], q.sdi_s2};
            if (q.cnt <= 5'(dac_ctrl_pkg::FRAME_BITS)) begin
              n.cnt = q.cnt + 5'h01;
            end
          end
          // Readback advances on rising edges so it is steady at the host's sample
          if (sclk_rise) begin
            n.out_shift = {q.out_shift[22:0], 1'b0};
            n.sdo       = q.out_shift[22];
          end
        end
      end
      default: begin
        n.state  = dac_ctrl_pkg::RX_IDLE;
        n.sdo_oe = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      q       <= '0;
      q.state <= dac_ctrl_pkg::RX_IDLE;
      q.sclk_s1 <= 1'b1;
      q.sclk_s2 <= 1'b1;
      q.sclk_s3 <= 1'b1;
      q.sync_s1 <= 1'b1;
      q.sync_s2 <= 1'b1;
      q.sync_s3 <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign fr.frame_valid = q.valid;
  assign fr.frame_data  = q.shift;
  assign sdo_out        = q.sdo;
  assign sdo_oe_out     = q.sdo_oe;
endmodule

/* rtl/watchdog_timer.sv */
// Interface watchdog: millisecond tick divider and timeout counter
module watchdog_timer #(
  parameter int TICK_CYCLES = dac_ctrl_pkg::TICK_CYCLES  // Cycles per tick
) (
  input  wire logic sys_clk_in,  // System clock
  input  wire logic resetn_in,   // Synchronous reset, active low
  wd_if.timer       wd           // Control and fault
);
  typedef struct packed {
    logic [dac_ctrl_pkg::TICK_W-1:0]   tick;     // Divider
    logic [dac_ctrl_pkg::WD_CNT_W-1:0] count;    // Ticks since last keep-alive
    logic                              timeout;  // Fault
  } wd_st_t;

  wd_st_t q, n;
  logic   expire;

  // Count ticks; a fresh expiry beats a kick in the same cycle, while a
  // standing fault is cleared by the next kick even though count sits at limit
  always_comb begin
    n      = q;
    expire = (q.count >= dac_ctrl_pkg::wd_limit(wd.sel));
    if (!wd.enable) begin
      n = '0;
    end else begin
      n.timeout = (expire & ~q.timeout) | (q.timeout & ~wd.kick);
      if (wd.kick) begin
        n.tick  = '0;
        n.count = '0;
      end else if (q.tick == dac_ctrl_pkg::TICK_W'(TICK_CYCLES - 1)) begin
        n.tick = '0;
        if (!expire) begin
          n.count = q.count + 1'b1;
        end
      end else begin
        n.tick = q.tick + 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign wd.timeout = q.timeout;
endmodule

/* sim/dac_bank_props.sv */
// Pin-level checks for the DAC control register bank
module dac_bank_props (
  input wire logic        sys_clk_in,          // System clock
  input wire logic        resetn_in,           // Synchronous reset, active low
  input wire logic        sync_n_in,           // Frame select pin
  input wire logic        clear_in,            // Clear pin
  input wire logic        sdo_out,             // Serial data out
  input wire logic        sdo_oe_out,          // Serial data drive enable
  input wire logic [3:0]  output_enable_out,   // Output enables
  input wire logic [3:0]  converter_power_out, // Converter power
  input wire logic [3:0]  internal_enable_out, // Internal enables
  input wire logic [3:0]  sense_select_out,    // Sense resistor select
  input wire logic [11:0] range_out,           // Range codes
  input wire logic [3:0]  channel_clear_out,   // Channels being cleared
  input wire logic        alert_out            // Watchdog fault
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  logic [3:0] range_ok;  // Channel holds one of the defined codes
  // Per-channel legality of the range field
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      range_ok[k] = range_out[3*k +: 3] inside {3'h4, 3'h5, 3'h6};
    end
  end
  // Frame select idle long enough for any frame to have landed
  sequence s_idle8;
    sync_n_in [*8];
  endsequence
  // Reset is checked while asserted, so it may not disable itself
  property p_reset_image;
    disable iff (1'b0) !resetn_in |=> range_out == 12'h924 && output_enable_out == 4'h0
      && converter_power_out == 4'h0 && internal_enable_out == 4'h0 && alert_out == 1'b0;
  endproperty
  property p_range_valid;
    range_ok == 4'hf;
  endproperty
  property p_quiet_enables;
    s_idle8 |=> $stable(output_enable_out) && $stable(converter_power_out);
  endproperty
  property p_quiet_config;
    s_idle8 |=> $stable({internal_enable_out, sense_select_out, range_out});
  endproperty
  property p_idle_sdo;
    s_idle8 |-> !sdo_oe_out && !sdo_out;
  endproperty
  property p_no_clear;
    !clear_in [*5] |-> channel_clear_out == 4'h0;
  endproperty
  property p_clear_cause;
    channel_clear_out != 4'h0 |-> $past(clear_in, 2) || $past(clear_in, 3) || $past(clear_in, 4);
  endproperty
  // Only a frame may clear a raised fault
  property p_alert_holds;
    s_idle8 ##1 (sync_n_in && alert_out) |=> alert_out;
  endproperty
  a_reset_image: assert property (p_reset_image) else $error("Reset image wrong");
  a_range_valid: assert property (p_range_valid) else $error("Range code illegal");
  a_quiet_enables: assert property (p_quiet_enables) else $error("Enables moved");
  a_quiet_config: assert property (p_quiet_config) else $error("Config moved");
  a_idle_sdo: assert property (p_idle_sdo) else $error("Serial out driven idle");
  a_no_clear: assert property (p_no_clear) else $error("Clear without pin");
  a_clear_cause: assert property (p_clear_cause) else $error("Clear has no cause");
  a_alert_holds: assert property (p_alert_holds) else $error("Alert dropped");
endmodule

bind quad_dac_control_register_bank dac_bank_props u_props (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .sync_n_in(sync_n_in),
  .clear_in(clear_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
  .output_enable_out(output_enable_out), .converter_power_out(converter_power_out),
  .internal_enable_out(internal_enable_out), .sense_select_out(sense_select_out),
  .range_out(range_out), .channel_clear_out(channel_clear_out), .alert_out(alert_out)
);

/* sim/host_serial_model.sv */
// Host-side serial master sending write frames to the bank
module host_serial_model (
  output logic      sclk_out,   // Serial clock, idles high
  output logic      sync_n_out, // Frame select, active low
  output logic      sdi_out,    // Serial data towards the device
  input  wire logic sdo_in,     // Serial data from the device
  input  wire logic sdo_oe_in   // Device drives serial data
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5;  // Half of the 125 ns serial clock
  initial begin
    sclk_out = 1'b1;
    sync_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // One frame MSB first; returned status captured on each falling edge
  task automatic send_frame(input logic [23:0] frame, output logic [23:0] status);
    #1;
    sync_n_out = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi_out = frame[i];
      #HALF;
      sclk_out = 1'b0;
      status[i] = sdo_oe_in ? sdo_in : 1'bz;
      #HALF;
      sclk_out = 1'b1;
    end
    #HALF;
    sync_n_out = 1'b1;
    sdi_out = ~sdi_out;  // Released line must not keep the last bit
    #300;
  endtask
endmodule

/* sim/test_quad_dac_control_register_bank.sv */
// Self-checking bench for the DAC control register bank
module test_quad_dac_control_register_bank;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK = 200;             // Shortened watchdog tick
  localparam logic [1:0] DEV = 2'h2;     // Strapped device address
  localparam logic [2:0] GLB = dac_ctrl_pkg::CTL_GLOBAL;
  localparam logic [2:0] CHN = dac_ctrl_pkg::CTL_CHANNEL;
  localparam logic [2:0] SWR = dac_ctrl_pkg::CTL_SOFTWARE;
  logic        sys_clk_in = 1'b0;        // System clock
  logic        resetn_in = 1'b0;         // Reset, active low
  logic        clear_in = 1'b0;          // Clear pin
  logic [1:0]  dev_addr_in = DEV;        // Address straps
  logic        sclk, sync_n, sdi, sdo, sdo_oe;
  logic [3:0]  oe, pw, ie, ss, cc;       // Channel outputs
  logic [11:0] rng;                      // Range codes
  logic        alert;                    // Watchdog fault
  logic [23:0] rb;                       // Status returned by last frame
  int          err_total = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  quad_dac_control_register_bank #(.TICK_CYCLES(TICK)) dut (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .sclk_in(sclk), .sync_n_in(sync_n),
    .sdi_in(sdi), .dev_addr_in(dev_addr_in), .clear_in(clear_in), .sdo_out(sdo),
    .sdo_oe_out(sdo_oe), .output_enable_out(oe), .converter_power_out(pw),
    .internal_enable_out(ie), .sense_select_out(ss), .range_out(rng),
    .channel_clear_out(cc), .alert_out(alert));
  host_serial_model host (.sclk_out(sclk), .sync_n_out(sync_n), .sdi_out(sdi),
    .sdo_in(sdo), .sdo_oe_in(sdo_oe));
  // Hang guard, well above the longest watchdog wait
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Control write frame for this device
  function automatic logic [23:0] cw(input logic [2:0] c, input logic [1:0] ch,
                                     input logic [12:0] low);
    return {1'b0, DEV, dac_ctrl_pkg::SEL_CONTROL, ch, c, low};
  endfunction
  task automatic send(input logic [23:0] f);
    host.send_frame(f, rb);
    repeat (2) @(posedge sys_clk_in);
  endtask
  initial begin
    logic [8:0]  cfg [4] = '{9'h154, 9'h0b5, 9'h1f6, 9'h005};  // Bits 8..0 per channel
    int          lim [4] = '{5, 10, 100, 200};                 // Timeouts in ticks
    logic [23:0] bad [4];
    bad = '{cw(CHN, 2'h0, 13'h0) | 24'h800000, cw(CHN, 2'h0, 13'h0) ^ 24'h600000,
            cw(CHN, 2'h0, 13'h0) ^ 24'h040000, cw(3'h0, 2'h0, 13'h0)};
    repeat (3) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk({oe, pw, ie, ss, alert, rng}, {17'h0, 12'h924}, "reset image");
    chk(cc, 4'h0, "reset clear image");
    foreach (cfg[k]) send(cw(CHN, 2'(k), {4'h0, cfg[k]}));
    chk(ie, 4'h5, "internal enable");
    chk(oe, 4'h5, "output enable");
    chk(ss, 4'h6, "sense select");
    chk(pw, 4'h7, "converter power");
    chk(rng, 12'hbac, "ranges");
    clear_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    chk(cc, 4'h6, "clear follows enable");
    clear_in <= 1'b0;
    // Undefined range code on channel 1, output enable newly set
    send(cw(CHN, 2'h1, 13'h00f7));
    chk({oe, rng}, {4'h7, 12'hbac}, "bad range kept");
    // Read flag, wrong address, data selector, slew selector: all ignored
    foreach (bad[i]) send(bad[i]);
    chk({oe, ie}, {4'h7, 4'h5}, "refused frames");
    // Channel enables cleared first, so the global bits are not mixed in
    for (int k = 0; k < 3; k++) send(cw(CHN, 2'(k), 13'h0004));
    chk({oe, pw, ie}, 12'h000, "channels powered down");
    send(cw(GLB, 2'h0, 13'h0030));
    chk({oe, pw}, 8'hff, "global enables");
    // Outputs go off before the converters do
    send(cw(GLB, 2'h0, 13'h0010));
    chk({oe, pw}, 8'h0f, "global outputs off");
    send(cw(GLB, 2'h0, 13'h0000));
    chk(pw, 4'h0, "global converters off");
    send(cw(GLB, 2'h0, 13'h0800));
    send(cw(SWR, 2'h0, 13'h1000));
    send(cw(SWR, 2'h0, 13'h1000));
    chk(rb, 24'h000800, "status user bit");
    foreach (lim[s]) begin
      send(cw(GLB, 2'h0, {3'b011, 2'(s), 8'h00}));
      repeat (lim[s] * TICK - TICK - 60) @(posedge sys_clk_in);
      chk(alert, 1'b0, "alert early");
      repeat (TICK + 60) @(posedge sys_clk_in);
      chk(alert, 1'b1, "alert missing");
      send(cw(SWR, 2'h0, 13'h0000));
      chk(alert, 1'b1, "other code kicked");
      chk(rb[0], 1'b1, "status shows alert");
      send(cw(SWR, 2'h0, 13'h0195));
      chk(alert, 1'b0, "keep-alive ignored");
      send(cw(GLB, 2'h0, 13'h0000));
    end
    send(cw(GLB, 2'h0, 13'h0430));
    repeat (4) send(cw(SWR, 2'h0, 13'h0195));
    chk(alert, 1'b0, "kept alive");
    send(cw(SWR, 2'h0, 13'h0555));
    chk({oe, pw, ie, ss, alert, rng}, {17'h0, 12'h924}, "software reset");
    repeat (1200) @(posedge sys_clk_in);
    chk(alert, 1'b0, "watchdog off after reset");
    final_report();
  end
endmodule
